// ===== src/pmrs_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module pmrs_sequencer
  import pmrs_pkg::*;
#(
  parameter int unsigned HOLDOFF_CYCLES = HOLDOFF_CYC,
  parameter int unsigned WAKE_CYCLES = XFER_CYC
) (
  // clock and reset (reset stands for loss of power)
  input wire logic clock,
  input wire logic reset,
  // supply monitor
  input wire logic supply_ok,
  // pins from the host
  input wire logic mode_select_pin,
  input wire logic reset_pin_n,
  input wire logic select_pin_n,
  // register writes decoded by the serial port
  input wire logic flags_high_wr,
  input wire logic [31:0] flags_high_wdata,
  input wire logic port_lock_cfg_wr,
  input wire logic [7:0] port_lock_cfg_wdata,
  input wire logic main_cfg_wr,
  input wire logic [15:0] main_cfg_wdata,
  input wire logic mask_high_wr,
  input wire logic [31:0] mask_high_wdata,
  input wire logic run_wr,
  input wire logic [15:0] run_wdata,
  // register contents
  output logic [31:0] event_flags_high,
  output logic [7:0] port_lock_cfg,
  output logic [15:0] main_cfg,
  output logic [31:0] mask_high,
  output logic [15:0] run_reg,
  // status
  output logic event_request_line_b_n,
  output logic normal_power_mode,
  output logic sleep_power_mode,
  output logic ports_enabled,
  output logic spi_selected,
  output logic port_locked,
  output logic dsp_running,
  output logic regs_defaulting
);
  localparam int unsigned CW = 32;

  pmrs_state_e state_r;
  logic [CW-1:0] cnt_r;
  logic mode_lvl;
  logic rst_lvl;
  logic sel_lvl;
  logic sel_prev_r;
  logic [1:0] sel_falls_r;
  logic first_entry_done_r;
  logic done_pulse;
  logic defaults_all;
  logic defaults_ctl;
  logic reset_done_flag_r;
  logic wake_req;
  logic sel_fall;
  logic sw_req;
  logic clear_done;

  pmrs_pin_sync #(.INIT(1'b1)) u_mode_sync (
    .clock(clock),
    .reset(reset),
    .pin(mode_select_pin),
    .level(mode_lvl)
  );

  pmrs_pin_sync #(.INIT(1'b1)) u_rst_sync (
    .clock(clock),
    .reset(reset),
    .pin(reset_pin_n),
    .level(rst_lvl)
  );

  pmrs_pin_sync #(.INIT(1'b1)) u_sel_sync (
    .clock(clock),
    .reset(reset),
    .pin(select_pin_n),
    .level(sel_lvl)
  );

  assign wake_req = !mode_lvl;
  assign sw_req = main_cfg_wr && main_cfg_wdata[SOFT_RESET_POS];
  assign sel_fall = sel_prev_r && !sel_lvl;
  assign clear_done = flags_high_wr && flags_high_wdata[FLAG_RESET_DONE_FLAG_POS];

  // power state sequencing
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= PMRS_INACTIVE;
      cnt_r <= '0;
    end else begin
      case (state_r)
        PMRS_INACTIVE: begin
          // hold-off counted from the supply threshold
          if (!supply_ok) begin
            cnt_r <= '0;
          end else if (cnt_r >= CW'(HOLDOFF_CYCLES - 1)) begin
            cnt_r <= '0;
            state_r <= PMRS_SLEEP;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        PMRS_SLEEP: begin
          cnt_r <= '0;
          if (wake_req) begin
            state_r <= PMRS_WAKE;
          end
        end
        PMRS_WAKE: begin
          // wake-up length is far below the 40 ms limit
          if (cnt_r >= CW'(WAKE_CYCLES - 1)) begin
            cnt_r <= '0;
            state_r <= PMRS_NORMAL;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        PMRS_NORMAL: begin
          cnt_r <= '0;
          if (!wake_req) begin
            state_r <= PMRS_SLEEP;
          end else if (!rst_lvl) begin
            state_r <= PMRS_HW_RST;
          end else if (sw_req) begin
            state_r <= PMRS_SW_RST;
          end
        end
        PMRS_HW_RST: begin
          // release only counts after the minimum low time
          if (!rst_lvl) begin
            if (cnt_r < CW'(RST_MIN_CYC)) begin
              cnt_r <= cnt_r + 1'b1;
            end
          end else if (cnt_r >= CW'(RST_MIN_CYC)) begin
            cnt_r <= '0;
            state_r <= PMRS_NORMAL;
          end else begin
            // too short a pulse: drop it; only run_reg was defaulted and reset-done cleared
            cnt_r <= '0;
            state_r <= PMRS_NORMAL;
          end
        end
        PMRS_SW_RST: begin
          if (cnt_r >= CW'(XFER_CYC - 1)) begin
            cnt_r <= '0;
            state_r <= PMRS_NORMAL;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        default: begin
          state_r <= PMRS_INACTIVE;
          cnt_r <= '0;
        end
      endcase
    end
  end

  // end-of-transition strobe and which registers default
  always_comb begin
    done_pulse = 1'b0;
    defaults_all = 1'b0;
    defaults_ctl = 1'b0;
    case (state_r)
      PMRS_WAKE: begin
        done_pulse = (cnt_r >= CW'(WAKE_CYCLES - 1));
        defaults_ctl = done_pulse;
        defaults_all = done_pulse && !first_entry_done_r;
      end
      PMRS_HW_RST: begin
        done_pulse = rst_lvl && (cnt_r >= CW'(RST_MIN_CYC));
        defaults_all = done_pulse;
        defaults_ctl = done_pulse;
      end
      PMRS_SW_RST: begin
        done_pulse = (cnt_r >= CW'(XFER_CYC - 1));
        defaults_ctl = done_pulse;
      end
      default: begin
        done_pulse = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      first_entry_done_r <= 1'b0;
    end else if (done_pulse && state_r == PMRS_WAKE) begin
      first_entry_done_r <= 1'b1;
    end
  end

  // reset-done: set wins over a clear in the same cycle; cleared on entry
  always_ff @(posedge clock) begin
    if (reset) begin
      reset_done_flag_r <= 1'b0;
    end else if (done_pulse) begin
      reset_done_flag_r <= 1'b1;
    end else if (state_r == PMRS_WAKE || state_r == PMRS_HW_RST ||
                 state_r == PMRS_SW_RST) begin
      reset_done_flag_r <= 1'b0;
    end else if (clear_done && state_r == PMRS_NORMAL) begin
      reset_done_flag_r <= 1'b0;
    end
  end

  // line b ignores the mask bit for this event
  always_ff @(posedge clock) begin
    if (reset) begin
      event_request_line_b_n <= 1'b1;
    end else begin
      event_request_line_b_n <= !(reset_done_flag_r || done_pulse);
    end
  end

  // the other flag bits live elsewhere; this block owns only reset-done
  always_comb begin
    event_flags_high = 32'h0000_0000;
    event_flags_high[FLAG_RESET_DONE_FLAG_POS] = reset_done_flag_r;
  end

  // port-lock config survives everything except power-up and reset pin
  always_ff @(posedge clock) begin
    if (reset || defaults_all) begin
      port_lock_cfg <= PORT_LOCK_RST;
    end else if (port_lock_cfg_wr && state_r == PMRS_NORMAL) begin
      port_lock_cfg <= port_lock_cfg_wdata;
    end
  end

  // serial port choice
  always_ff @(posedge clock) begin
    if (reset || defaults_all) begin
      spi_selected <= 1'b0;
      port_locked <= 1'b0;
      sel_falls_r <= 2'h0;
      sel_prev_r <= 1'b1;
    end else begin
      sel_prev_r <= sel_lvl;
      if (state_r == PMRS_NORMAL && !port_locked) begin
        if (!spi_selected && port_lock_cfg_wr &&
            port_lock_cfg_wdata[LOCK_TWI_POS]) begin
          port_locked <= 1'b1;
        end else if (spi_selected && port_lock_cfg_wr) begin
          port_locked <= 1'b1;
        end else if (!spi_selected && sel_fall) begin
          if (sel_falls_r == 2'(SEL_FALLS_FOR_SPI - 1)) begin
            spi_selected <= 1'b1;
          end else begin
            sel_falls_r <= sel_falls_r + 2'h1;
          end
        end
      end
    end
  end

  // control registers, defaulted at the end of every wake, soft reset and full-length reset pin pulse
  always_ff @(posedge clock) begin
    if (reset || defaults_ctl) begin
      main_cfg <= MAIN_CFG_RST;
      mask_high <= MASK_RST;
    end else if (state_r == PMRS_NORMAL) begin
      if (main_cfg_wr) begin
        main_cfg <= main_cfg_wdata;
      end
      if (mask_high_wr) begin
        mask_high <= mask_high_wdata;
      end
    end
  end

  // processor idles until started after init
  always_ff @(posedge clock) begin
    if (reset || defaults_ctl || state_r != PMRS_NORMAL) begin
      run_reg <= RUN_RST;
    end else if (run_wr) begin
      run_reg <= run_wdata;
    end
  end

  assign dsp_running = (run_reg == RUN_START);
  assign normal_power_mode = (state_r == PMRS_NORMAL);
  assign sleep_power_mode = (state_r == PMRS_SLEEP) ||
                            (state_r == PMRS_INACTIVE);
  assign ports_enabled = (state_r == PMRS_NORMAL);
  assign regs_defaulting = defaults_ctl;
endmodule // pmrs_sequencer
`default_nettype wire

// ===== src/pmrs_pkg.sv
// What this block does
// - mode pin low selects normal mode, high selects sleep mode.
// - power-up always lands in sleep until the host pulls mode pin low.
// - sleep to normal defaults control registers but keeps port-lock config.
// - first normal entry after power-up defaults everything, port-lock included.
// - reset-done reads 0 during transitions, then 1 with line b low.
// - writing 1 to reset-done clears it and releases line b high.
// - reset-done is unmaskable; mask bit 15 has no effect on line b.
// - in sleep no serial or capture port responds.
// - device stays inactive 26 ms after supply threshold is reached.
// - sleep to normal transition completes in under 40 ms.
// - two-wire port active after power-up or reset pin defaults; three select falls switch to SPI.
// - port-lock bit 1 set locks two-wire; select toggles then ignored.
// - any port-lock config write while SPI is active locks SPI.
// - locked choice survives mode changes; only power loss or reset pin clears.
// - signal processor idles after any reset until run register gets 0x0001.
// - reset pin acts only in normal mode.
// - reset pin low at least 10 us then released defaults all, then reset-done.
// - soft-reset bit 7 in normal mode defaults registers, keeps port-lock.
// - at soft-reset end bit clears itself, line b goes low, flag sets.
// - soft reset is ignored in sleep mode.
package pmrs_pkg;
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned HOLDOFF_MS = 26;
  localparam int unsigned WAKE_MAX_MS = 40;
  localparam int unsigned RST_MIN_US = 10;
  localparam int unsigned XFER_US = 100;
  localparam int unsigned HOLDOFF_CYC = HOLDOFF_MS * (CLK_HZ / 1000);
  localparam int unsigned WAKE_MAX_CYC = WAKE_MAX_MS * (CLK_HZ / 1000);
  localparam int unsigned RST_MIN_CYC = RST_MIN_US * (CLK_HZ / 1_000_000);
  localparam int unsigned XFER_CYC = XFER_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FLAG_RESET_DONE_FLAG_POS = 15;
  localparam int unsigned MASK_RESET_DONE_FLAG_POS = 15;
  localparam int unsigned LOCK_TWI_POS = 1;
  localparam int unsigned SOFT_RESET_POS = 7;
  localparam logic [15:0] RUN_START = 16'h0001;
  localparam logic [7:0] PORT_LOCK_RST = 8'h00;
  localparam logic [15:0] MAIN_CFG_RST = 16'h0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [15:0] RUN_RST = 16'h0000;
  localparam int unsigned SEL_FALLS_FOR_SPI = 3;
  typedef enum {
    PMRS_INACTIVE, PMRS_SLEEP, PMRS_WAKE, PMRS_NORMAL, PMRS_HW_RST,
    PMRS_SW_RST
  } pmrs_state_e;
endpackage

// ===== src/pmrs_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
// three-stage pin synchroniser; output changes once stages two and three agree
module pmrs_pin_sync #(
  parameter logic INIT = 1'b1
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // pin and clean level
  input wire logic pin,
  output logic level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      level <= INIT;
    end else if (s2_r == s3_r) begin
      level <= s3_r;
    end
  end
endmodule // pmrs_pin_sync
`default_nettype wire

// ===== dv/pmrs_sequencer_chk.sv
`timescale 1ns/100ps
`default_nettype none
module pmrs_sequencer_chk
  import pmrs_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // inputs watched
  input wire logic mode_select_pin,
  input wire logic flags_high_wr,
  input wire logic [31:0] flags_high_wdata,
  input wire logic port_lock_cfg_wr,
  input wire logic run_wr,
  input wire logic [15:0] run_wdata,
  // outputs watched
  input wire logic [31:0] event_flags_high,
  input wire logic [15:0] main_cfg,
  input wire logic event_request_line_b_n,
  input wire logic normal_power_mode,
  input wire logic sleep_power_mode,
  input wire logic ports_enabled,
  input wire logic spi_selected,
  input wire logic port_locked,
  input wire logic dsp_running
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // line b falls with the flag but releases one edge after a clear
  property p_line_b;
    event_request_line_b_n == !($past(event_flags_high[FLAG_RESET_DONE_FLAG_POS]) ||
      $rose(event_flags_high[FLAG_RESET_DONE_FLAG_POS]));
  endproperty
  a_line_b: assert property (p_line_b) else $error("line b wrong");
  property p_clear;
    flags_high_wr && flags_high_wdata[15] && normal_power_mode &&
      event_flags_high[15] |=> !event_flags_high[15] ##1 event_request_line_b_n;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  property p_sleep_ports;
    sleep_power_mode |-> !ports_enabled && !normal_power_mode;
  endproperty
  a_sleep_ports: assert property (p_sleep_ports) else $error("ports on");
  property p_dsp_idle;
    sleep_power_mode && $past(sleep_power_mode) |-> !dsp_running;
  endproperty
  a_dsp_idle: assert property (p_dsp_idle) else $error("dsp runs");
  property p_run;
    run_wr && run_wdata == RUN_START && normal_power_mode |=> dsp_running;
  endproperty
  a_run: assert property (p_run) else $error("dsp not started");
  property p_twi_lock;
    port_locked && !spi_selected |=> !spi_selected;
  endproperty
  a_twi_lock: assert property (p_twi_lock) else $error("spi taken");
  property p_spi_lock;
    spi_selected && port_lock_cfg_wr && normal_power_mode |=> port_locked;
  endproperty
  a_spi_lock: assert property (p_spi_lock) else $error("spi unlocked");
  property p_wake;
    sleep_power_mode && !mode_select_pin |-> ##[1:100] normal_power_mode;
  endproperty
  a_wake: assert property (p_wake) else $error("wake too slow");
  property p_soft_reset_bit;
    $rose(event_flags_high[15]) |-> !main_cfg[SOFT_RESET_POS];
  endproperty
  a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("soft reset bit");
  c_irq: cover property ($fell(event_request_line_b_n));
  c_spi: cover property (spi_selected && port_locked);
  c_twi: cover property (!spi_selected && port_locked);
endmodule // pmrs_sequencer_chk
`default_nettype wire

// ===== dv/pmrs_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module pmrs_host_model (
  // clock
  input wire logic clock,
  // host pins
  output var logic mode_select_pin,
  output var logic reset_pin_n,
  output var logic select_pin_n
);
  // pins rest high, as the pull-up leaves the mode pin
  initial begin
    mode_select_pin = 1'b1;
    reset_pin_n = 1'b1;
    select_pin_n = 1'b1;
  end
  task automatic set_mode(input logic m);
    @(posedge clock);
    #1 mode_select_pin = m;
  endtask
  task automatic pulse_reset(input int n);
    @(posedge clock);
    #1 reset_pin_n = 1'b0;
    repeat (n) @(posedge clock);
    #1 reset_pin_n = 1'b1;
  endtask
  // each level held 8 clocks so the synchroniser sees every fall
  // an spi host repeats this right after a reset pin pulse
  task automatic toggle_select;
    repeat (3) begin
      @(posedge clock);
      #1 select_pin_n = 1'b0;
      repeat (8) @(posedge clock);
      #1 select_pin_n = 1'b1;
      repeat (8) @(posedge clock);
    end
  endtask
endmodule // pmrs_host_model
`default_nettype wire

// ===== dv/tb_pmrs_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module tb_pmrs_sequencer;
  import pmrs_pkg::*;
  logic clock = 1'b0, reset = 1'b1, supply_ok = 1'b0, probe = 1'b0;
  logic mode_select_pin, reset_pin_n, select_pin_n;
  logic flags_high_wr, port_lock_cfg_wr, main_cfg_wr, mask_high_wr, run_wr;
  logic [31:0] flags_high_wdata, mask_high_wdata, event_flags_high, mask_high;
  logic [7:0] port_lock_cfg_wdata, port_lock_cfg, seen, c;
  logic [15:0] main_cfg_wdata, run_wdata, main_cfg, run_reg;
  logic event_request_line_b_n, normal_power_mode, sleep_power_mode;
  logic ports_enabled, spi_selected, port_locked, dsp_running, regs_defaulting;
  logic [4:0] wr_s = 5'h00;
  logic [31:0] wv = 32'h0000_0000;
  logic [7:0] notes[$];
  int seed = 32'h19c0049b;
  int num_errors = 0, n_checks = 0;
  always #4 clock = ~clock;
  assign {flags_high_wr, port_lock_cfg_wr, main_cfg_wr} = wr_s[4:2];
  assign {mask_high_wr, run_wr} = wr_s[1:0];
  assign flags_high_wdata = wv;
  assign mask_high_wdata = wv;
  assign port_lock_cfg_wdata = wv[7:0];
  assign main_cfg_wdata = wv[15:0];
  assign run_wdata = wv[15:0];
  assign seen = {~event_request_line_b_n, event_flags_high[15], port_locked,
    spi_selected, main_cfg[7], port_lock_cfg[1], dsp_running, sleep_power_mode};
  pmrs_sequencer #(.HOLDOFF_CYCLES(20), .WAKE_CYCLES(40)) pmrs_sequencer_i (.*);
  pmrs_host_model pmrs_host_model_i (.*);
  always @(posedge clock) begin
    if (probe || $fell(event_request_line_b_n)) begin
      n_checks++;
      if (notes.size() == 0) notes.push_back(~seen);
      if (seen !== notes[0]) begin
        num_errors++;
        $display("MISMATCH status exp %h seen %h", notes[0], seen);
      end
      void'(notes.pop_front());
    end
  end
  task automatic wr(input int k, input logic [31:0] v);
    @(posedge clock);
    #1 wr_s = 5'h10 >> k;
    wv = v;
    @(posedge clock);
    #1 wr_s = 5'h00;
  endtask
  task automatic chk(input logic [7:0] e);
    notes.push_back(e);
    @(posedge clock);
    #1 probe = 1'b1;
    @(posedge clock);
    #1 probe = 1'b0;
  endtask
  task automatic irq(input logic [7:0] e, input int lim);
    notes.push_back(e);
    while (event_request_line_b_n !== 1'b0 && lim > 0) begin
      @(posedge clock) #1;
      lim--;
    end
    if (event_request_line_b_n !== 1'b0) begin
      num_errors++;
      $display("MISMATCH line_b exp 0 seen 1");
      report_and_stop;
    end
    repeat (2) @(posedge clock);
  endtask
  task automatic clr(input logic [7:0] e);
    wr(0, $random(seed) | 32'h0000_8000);
    chk(e);
  endtask
  task automatic report_and_stop;
    // a note never answered is a missing result
    if (notes.size() != 0) num_errors++;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clock);
    #1 reset = 1'b0;
    repeat (10) @(posedge clock);
    #1 supply_ok = 1'b1;
    repeat (40) @(posedge clock);
    wr(2, 32'h0000_0080);
    chk(8'h01);
    $display("test power-up done");
    pmrs_host_model_i.set_mode(1'b0);
    irq(8'hc0, 200);
    wr(3, 32'hffff_ffff);
    n_checks++;
    if (mask_high !== 32'hffff_ffff) begin
      num_errors++;
      $display("MISMATCH mask_high exp ffffffff seen %h", mask_high);
    end
    clr(8'h00);
    $display("test wake done");
    pmrs_host_model_i.toggle_select;
    wv = $random(seed);
    c = {5'h00, wv[1], 2'h0};
    wr(1, wv);
    chk(8'h30 | c);
    wr(4, 32'h0000_0001);
    chk(8'h32 | c);
    $display("test spi lock done");
    wr(2, 32'h0000_0080);
    irq(8'hf0 | c, 13000);
    clr(8'h30 | c);
    $display("test soft reset done");
    wr(4, 32'h0000_0000);
    wr(3, 32'h0000_0000);
    pmrs_host_model_i.set_mode(1'b1);
    repeat (20) @(posedge clock);
    pmrs_host_model_i.pulse_reset(1300);
    wr(2, 32'h0000_0080);
    chk(8'h31 | c);
    pmrs_host_model_i.set_mode(1'b0);
    irq(8'hf0 | c, 200);
    clr(8'h30 | c);
    $display("test sleep cycle done");
    pmrs_host_model_i.pulse_reset(100);
    repeat (20) @(posedge clock);
    chk(8'h30 | c);
    pmrs_host_model_i.pulse_reset(1300);
    irq(8'hc0, 200);
    clr(8'h00);
    $display("test hardware reset done");
    wr(1, 32'h0000_0002);
    chk(8'h24);
    pmrs_host_model_i.toggle_select;
    repeat (10) @(posedge clock);
    chk(8'h24);
    $display("test two-wire lock done");
    report_and_stop;
  end
endmodule // tb_pmrs_sequencer
bind pmrs_sequencer pmrs_sequencer_chk pmrs_sequencer_chk_i (.*);
`default_nettype wire
